// [hdl/acs_sequencer.sv]
// Conversion sequencer and result formatter for an incremental ADC.
// Assumes an AXI4-Lite master and a modulator bit from the analog side.
// What this block does
// - A conversion lasts N*(OSR+1)+1 sampling periods.
// - The 16-bit two's complement result is read as high and low bytes.
// - Out-of-range results clamp to 0x7FFF or 0x8000.
// - Below 16-bit resolution the unused low bits are forced.
// - The forced pattern is a one then zeros, shorter as settings grow.
// - Converter bias code picks quarter to full current, limiting rate.
// - Amplifier bias scales alike; the lower bias bounds the rate.
// - Software may disable amplifiers and converter while idle.
// - Setting the start or alternate trigger bit begins a conversion.
// - Oversampling field, config bits 4 to 2, gives OSR 8 to 1024.
// - Field bits 6 to 5 give 1 to 8 chopped elementary conversions.
// - Sample rate is RC/4, RC/8, RC/32 or about 8 kHz.
`timescale 1ns/1ps
module acs_sequencer
  import acs_pkg::*;
#(
  parameter logic [15:0] RC_CYCLES   = RC_PERIOD_CYCLES,
  parameter logic [15:0] SLOW_CYCLES = SLOW_PERIOD_CYCLES
) (
  input  wire logic              aclk,             // Clock.
  input  wire logic              aresetn,          // Sync reset.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,     // Write address.
  input  wire logic              s_axi_awvalid,    // Address valid.
  output logic                   s_axi_awready,    // Address ready.
  input  wire logic [31:0]       s_axi_wdata,      // Write data.
  input  wire logic [3:0]        s_axi_wstrb,      // Byte enables.
  input  wire logic              s_axi_wvalid,     // Data valid.
  output logic                   s_axi_wready,     // Data ready.
  output logic [1:0]             s_axi_bresp,      // Write response.
  output logic                   s_axi_bvalid,     // Response valid.
  input  wire logic              s_axi_bready,     // Response ready.
  input  wire logic [ADDR_W-1:0] s_axi_araddr,     // Read address.
  input  wire logic              s_axi_arvalid,    // Address valid.
  output logic                   s_axi_arready,    // Address ready.
  output logic [31:0]            s_axi_rdata,      // Read data.
  output logic [1:0]             s_axi_rresp,      // Read response.
  output logic                   s_axi_rvalid,     // Read valid.
  input  wire logic              s_axi_rready,     // Read ready.
  input  wire logic              modulator_bit,    // Modulator pin.
  output logic                   sample_tick,      // Sample strobe.
  output logic                   chop_phase,       // Offset polarity.
  output logic                   conv_busy,        // Converting.
  output logic                   conv_done,        // Result pulse.
  output logic                   converter_enable, // Converter power.
  output logic                   amplifier_enable, // Amplifier power.
  output logic [1:0]             converter_bias_select, // ADC bias.
  output logic [1:0]             amplifier_bias_select  // PGA bias.
);

  // ****************************************
  // Functions
  // ****************************************

  // Sampling period in clock cycles for a sample rate code.
  function automatic logic [15:0] period_of(input logic [1:0] sel);
    case (sel)
      2'b00:   period_of = 16'(RC_CYCLES * FIN_DIV_0);
      2'b01:   period_of = 16'(RC_CYCLES * FIN_DIV_1);
      2'b10:   period_of = 16'(RC_CYCLES * FIN_DIV_2);
      default: period_of = SLOW_CYCLES;
    endcase
  endfunction

  // Least sampling period allowed by a bias code.
  function automatic logic [15:0] limit_of(input logic [1:0] b);
    case (b)
      2'b00:   limit_of = LIMIT_CYC_0;
      2'b01:   limit_of = LIMIT_CYC_1;
      2'b10:   limit_of = LIMIT_CYC_2;
      default: limit_of = LIMIT_CYC_3;
    endcase
  endfunction

  // Sampling periods per elementary conversion, minus one: OSR.
  function automatic logic [10:0] osr_of(input acs_cfg_t c);
    osr_of = 11'(32'd8 << c.oversample_select);
  endfunction

  // Total sampling periods of one full conversion.
  function automatic logic [13:0] periods_of(input acs_cfg_t c);
    periods_of = 14'(((32'd1 << c.elem_conv_count_select) *
                      (32'(osr_of(c)) + 32'd1)) + 32'd1);
  endfunction

  // Count of forced low bits for a setting; zero at full resolution.
  function automatic logic [3:0] force_len(input acs_cfg_t c);
    case ({c.oversample_select, c.elem_conv_count_select})
      5'b000_00: force_len = 4'h9;
      5'b000_01: force_len = 4'h8;
      5'b000_10: force_len = 4'h7;
      5'b000_11: force_len = 4'h7;
      5'b001_00: force_len = 4'h8;
      5'b001_01: force_len = 4'h7;
      5'b001_10: force_len = 4'h6;
      5'b001_11: force_len = 4'h5;
      5'b010_00: force_len = 4'h6;
      5'b010_01: force_len = 4'h5;
      5'b010_10: force_len = 4'h4;
      5'b010_11: force_len = 4'h3;
      5'b011_00: force_len = 4'h4;
      5'b011_01: force_len = 4'h3;
      5'b011_10: force_len = 4'h2;
      5'b011_11: force_len = 4'h1;
      5'b100_00: force_len = 4'h2;
      5'b100_01: force_len = 4'h1;
      default:   force_len = 4'h0;
    endcase
  endfunction

  // ****************************************
  // Registers and bus slave
  // ****************************************
  acs_cfg_t    cfg;
  acs_cfg_t    run_cfg;
  acs_ctrl_t   ctrl;
  acs_state_t  state;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        start_pulse;
  logic        rate_violation;
  logic [15:0] result;
  logic        result_sat;
  logic        do_write;
  logic        run_enable;

  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign run_enable = ctrl.converter_enable && ctrl.amplifier_enable;
  assign converter_enable      = ctrl.converter_enable;
  assign amplifier_enable      = ctrl.amplifier_enable;
  assign converter_bias_select = ctrl.converter_bias_select;
  assign amplifier_bias_select = ctrl.amplifier_bias_select;

  // Address decode of the implemented words.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ACQ_CONFIG_OFF) || (a == ACQ_CONTROL_OFF) ||
             (a == ACQ_STATUS_OFF) || (a == RESULT_HIGH_OFF) ||
             (a == RESULT_LOW_OFF);
  endfunction

  // Write channels: take address and data in any order, then answer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Software-written fields; start bits are one-cycle strobes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg         <= CFG_RESET;
      ctrl        <= CTRL_RESET;
      start_pulse <= 1'b0;
    end else begin
      start_pulse <= 1'b0;
      if (do_write && w_strb[0] && aw_addr == ACQ_CONFIG_OFF) begin
        cfg <= acs_cfg_t'(w_data[CFG_NELC_MSB:CFG_OSR_LSB]);
      end
      if (do_write && aw_addr == ACQ_CONTROL_OFF) begin
        if (w_strb[0]) begin
          ctrl <= acs_ctrl_t'(w_data[7:0]);
        end
        if (w_strb[1]) begin
          start_pulse <= w_data[CTRL_START_BIT] ||
                         w_data[CTRL_ALT_BIT];
        end
      end
    end
  end

  // Read channel: one word per request, answered the next cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        ACQ_CONFIG_OFF:  s_axi_rdata <= {25'h0, cfg, 2'h0};
        ACQ_CONTROL_OFF: s_axi_rdata <= {24'h0, ctrl};
        ACQ_STATUS_OFF:  s_axi_rdata <= {30'h0, rate_violation, conv_busy};
        RESULT_HIGH_OFF: s_axi_rdata <= {24'h0, result[15:8]};
        RESULT_LOW_OFF:  s_axi_rdata <= {24'h0, result[7:0]};
        default:         s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Rate check against the lower of the two bias settings.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_violation <= 1'b0;
    end else begin
      rate_violation <= period_of(ctrl.sample_rate_select) <
        limit_of((ctrl.converter_bias_select < ctrl.amplifier_bias_select)
                 ? ctrl.converter_bias_select
                 : ctrl.amplifier_bias_select);
    end
  end

  // ****************************************
  // Sampling clock and sequencer
  // ****************************************
  logic [15:0]        div_cnt;
  logic               mod_meta;
  logic               mod_sync;
  logic [10:0]        period_cnt;
  logic [2:0]         elem_cnt;
  logic signed [15:0] acc;
  logic [13:0]        ticks_seen;

  // Divider making the sampling strobe; stopped while powered down.
  always_ff @(posedge aclk) begin
    if (!aresetn || !run_enable) begin
      div_cnt     <= 16'h0000;
      sample_tick <= 1'b0;
    end else if (div_cnt >= period_of(ctrl.sample_rate_select) - 16'h1)
    begin
      div_cnt     <= 16'h0000;
      sample_tick <= 1'b1;
    end else begin
      div_cnt     <= div_cnt + 16'h1;
      sample_tick <= 1'b0;
    end
  end

  // Two-stage synchroniser for the modulator pin.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_meta <= 1'b0;
      mod_sync <= 1'b0;
    end else begin
      mod_meta <= modulator_bit;
      mod_sync <= mod_meta;
    end
  end

  // Sequencer: elementary conversions, then one final period.
  always_ff @(posedge aclk) begin
    if (!aresetn || !run_enable) begin
      state      <= ST_IDLE;
      conv_busy  <= 1'b0;
      conv_done  <= 1'b0;
      chop_phase <= 1'b0;
      period_cnt <= 11'h000;
      elem_cnt   <= 3'h0;
      acc        <= 16'sh0000;
      ticks_seen <= 14'h0000;
      run_cfg    <= CFG_RESET;
    end else begin
      conv_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_pulse) begin
            state      <= ST_ELEM;
            conv_busy  <= 1'b1;
            run_cfg    <= cfg;
            chop_phase <= 1'b0;
            period_cnt <= 11'h000;
            elem_cnt   <= 3'h0;
            acc        <= 16'sh0000;
            ticks_seen <= 14'h0000;
          end
        end
        ST_ELEM: begin
          if (sample_tick) begin
            ticks_seen <= ticks_seen + 14'h1;
            acc <= (mod_sync ^ chop_phase) ? acc + 16'sh1 : acc - 16'sh1;
            if (period_cnt == osr_of(run_cfg)) begin
              period_cnt <= 11'h000;
              chop_phase <= !chop_phase;
              elem_cnt   <= elem_cnt + 3'h1;
              if (elem_cnt == 3'(3'h1 << run_cfg.elem_conv_count_select)
                              - 3'h1) begin
                state <= ST_FINAL;
              end
            end else begin
              period_cnt <= period_cnt + 11'h1;
            end
          end
        end
        ST_FINAL: begin
          if (sample_tick) begin
            ticks_seen <= ticks_seen + 14'h1;
            state      <= ST_IDLE;
            conv_busy  <= 1'b0;
            conv_done  <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Result formatting
  // ****************************************
  logic signed [31:0] scaled;
  logic [15:0]        mask;
  logic [15:0]        next_result;
  logic               next_sat;

  // Scale the chopped sum to 16 bits, clamp, then force low bits.
  always_comb begin
    scaled = 32'(acc) <<< (12 - int'(run_cfg.oversample_select)
                              - int'(run_cfg.elem_conv_count_select));
    mask = 16'((32'd1 << force_len(run_cfg)) - 32'd1);
    if (scaled > 32'sd32767) begin
      next_result = FULL_POS;
      next_sat    = 1'b1;
    end else if (scaled < -32'sd32768) begin
      next_result = FULL_NEG;
      next_sat    = 1'b1;
    end else begin
      next_result = (scaled[15:0] & ~mask) | (mask ^ (mask >> 1));
      next_sat    = 1'b0;
    end
  end

  // Result words change only when a conversion completes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result     <= 16'h0000;
      result_sat <= 1'b0;
    end else if (run_enable && state == ST_FINAL && sample_tick) begin
      result     <= next_result;
      result_sat <= next_sat;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_conv_length: assert property (conv_done |->
    ticks_seen == periods_of(run_cfg)) else $error("wrong length");
  a_result_high: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == RESULT_HIGH_OFF |=>
    s_axi_rdata[7:0] == $past(result[15:8]))
    else $error("high byte mismatch");
  a_sat_pos: assert property (state == ST_FINAL && sample_tick &&
    scaled > 32'sd32767 |=> result == FULL_POS) else $error("no clamp");
  a_sat_neg: assert property (state == ST_FINAL && sample_tick &&
    scaled < -32'sd32768 |=> result == FULL_NEG) else $error("no clamp");
  a_forced_bits: assert property (conv_done && !result_sat |->
    (result & mask) == (mask ^ (mask >> 1))) else $error("bad lsbs");
  a_rate_flag: assert property ($stable(ctrl) [*2] ##0 $past(aresetn)
    |-> rate_violation == (period_of(ctrl.sample_rate_select) <
    limit_of(ctrl.converter_bias_select) ||
    period_of(ctrl.sample_rate_select) <
    limit_of(ctrl.amplifier_bias_select))) else $error("rate flag");
  a_power_down: assert property (!run_enable |=>
    state == ST_IDLE && !conv_busy && !sample_tick)
    else $error("ran while off");
  a_start_run: assert property (state == ST_IDLE && start_pulse &&
    run_enable |=> conv_busy && state == ST_ELEM) else $error("no start");
  a_chop_flip: assert property (state == ST_ELEM && sample_tick &&
    period_cnt == osr_of(run_cfg) && run_enable |=> $changed(chop_phase))
    else $error("chop stuck");
  a_tick_gap: assert property (sample_tick |=> !sample_tick [*3])
    else $error("tick too fast");
  a_result_hold: assert property (!$past(conv_done) &&
    !conv_done |-> $stable(result)) else $error("result moved");

  c_done: cover property (conv_done);
  c_sat: cover property (conv_done && result_sat);
  c_rate: cover property ($rose(rate_violation));
  c_alt: cover property (conv_done && run_cfg.elem_conv_count_select != 0);

endmodule

// [hdl/acs_pkg.sv]
// Shared constants, types and register map of the conversion sequencer.
// Assumes a 200 MHz system clock and an AXI4-Lite register bus.
package acs_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int RC_PERIOD_NS  = 500;     // Default RC clock, 2 MHz.
  localparam int SLOW_PERIOD_NS = 125000; // The roughly 8 kHz rate.
  localparam logic [15:0] RC_PERIOD_CYCLES =
    16'(RC_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [15:0] SLOW_PERIOD_CYCLES =
    16'(SLOW_PERIOD_NS / CLK_PERIOD_NS);
  // RC dividers for sample rate codes 00, 01 and 10.
  localparam int FIN_DIV_0 = 4;
  localparam int FIN_DIV_1 = 8;
  localparam int FIN_DIV_2 = 32;
  // Least sampling period per bias code, rounded up to whole cycles.
  localparam int LIMIT_NS_0 = 16000;      // 62.5 kHz.
  localparam int LIMIT_NS_1 = 8000;       // 125 kHz.
  localparam int LIMIT_NS_2 = 4000;       // 250 kHz.
  localparam int LIMIT_NS_3 = 2000;       // 500 kHz.
  localparam logic [15:0] LIMIT_CYC_0 =
    16'((LIMIT_NS_0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] LIMIT_CYC_1 =
    16'((LIMIT_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] LIMIT_CYC_2 =
    16'((LIMIT_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] LIMIT_CYC_3 =
    16'((LIMIT_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************
  // Register map
  // ****************************************
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  ACQ_CONFIG_OFF  = 8'h00;
  localparam logic [7:0]  ACQ_CONTROL_OFF = 8'h04;
  localparam logic [7:0]  ACQ_STATUS_OFF  = 8'h08;
  localparam logic [7:0]  RESULT_HIGH_OFF = 8'h0C;
  localparam logic [7:0]  RESULT_LOW_OFF  = 8'h10;
  localparam int          CFG_OSR_LSB     = 2;
  localparam int          CFG_NELC_MSB    = 6;
  localparam int          CTRL_START_BIT  = 8;
  localparam int          CTRL_ALT_BIT    = 9;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  localparam logic [15:0] FULL_POS        = 16'h7FFF;
  localparam logic [15:0] FULL_NEG        = 16'h8000;

  // Fields of the acquisition configuration register.
  typedef struct packed {
    logic [1:0] elem_conv_count_select;
    logic [2:0] oversample_select;
  } acs_cfg_t;

  // Fields of the acquisition control register, bits 7 to 0.
  typedef struct packed {
    logic       converter_enable;
    logic       amplifier_enable;
    logic [1:0] amplifier_bias_select;
    logic [1:0] converter_bias_select;
    logic [1:0] sample_rate_select;
  } acs_ctrl_t;

  localparam acs_cfg_t  CFG_RESET  = 5'h00;
  localparam acs_ctrl_t CTRL_RESET = 8'h3C;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ELEM  = 2'b01,
    ST_FINAL = 2'b10
  } acs_state_t;

endpackage

// [verif/tb_top.sv]
// Self-checking testbench of the conversion sequencer, one instance.
// Assumes acs_pkg and acs_sequencer are compiled first; 200 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] %0t mismatch got %h exp %h", \
  $time, g, e); end end
module tb_top;
  import acs_pkg::*;
  // ****************************************
  // Signals and instance
  // ****************************************
  typedef struct {
    logic [2:0]  o;
    logic [1:0]  n;
    logic        m;
    logic [15:0] r;
  } acs_row_t;
  logic        aclk = 0, aresetn = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0]  wstrb = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, mbit = 0, awready, wready, bvalid, arready;
  logic        rvalid, tick, chop, busy, done, cen, aen;
  logic [1:0]  bresp, rresp, cbias, abias, resp;
  logic [31:0] d;
  int          miscompares = 0, samples_checked = 0, t, nt = 0;
  acs_row_t    rows [12] = '{'{0, 0, 1, 16'h7FFF}, '{0, 0, 0, 16'h8000},
    '{1, 0, 1, 16'h7FFF}, '{0, 1, 1, 16'h0080}, '{0, 2, 1, 16'h0040},
    '{0, 3, 0, 16'h0040}, '{1, 3, 1, 16'h0010}, '{2, 2, 1, 16'h0008},
    '{4, 1, 1, 16'h0001}, '{4, 2, 0, 16'h0000}, '{7, 3, 1, 16'h0000},
    '{3, 3, 1, 16'h0001}};
  int          per [4] = '{4, 8, 32, 40};
  acs_sequencer #(.RC_CYCLES(16'h0001), .SLOW_CYCLES(16'h0028))
    acs_sequencer_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .modulator_bit(mbit), .sample_tick(tick),
    .chop_phase(chop), .conv_busy(busy), .conv_done(done),
    .converter_enable(cen), .amplifier_enable(aen),
    .converter_bias_select(cbias), .amplifier_bias_select(abias));
  // Clock of 5 ns period.
  always #2.5 aclk = ~aclk;
  // ****************************************
  // Bus tasks
  // ****************************************
  // One AXI4-Lite write; address and data offered together.
  task automatic axw(input logic [7:0] a, input logic [31:0] v,
                     input logic [3:0] s);
    bit ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin ad = 1; awvalid <= 0; end
      if (wvalid && wready) begin wd = 1; wvalid <= 0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    // Bready stays high, so a following write never drives it twice at once.
  endtask
  // One AXI4-Lite read.
  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    resp = rresp;
    // Rready stays high, so a following read never drives it twice at once.
  endtask
  // Reads both result bytes and compares the joined word.
  task automatic chk_res(input logic [15:0] e);
    logic [15:0] w;
    axr(RESULT_HIGH_OFF);
    w[15:8] = d[7:0];
    axr(RESULT_LOW_OFF);
    w[7:0] = d[7:0];
    `CHK(w, e)
  endtask
  // Counts sampling ticks while a conversion runs, even during bus tasks.
  always @(posedge aclk) begin
    if (busy !== 1'b1) nt <= 0;
    else if (tick === 1'b1) nt <= nt + 1;
  end
  // Waits for the result pulse and takes the tick count of that conversion.
  task automatic wait_done();
    for (int i = 0; i < 40000 && done !== 1'b1; i++) @(posedge aclk);
    if (done !== 1'b1) miscompares++;
    t = nt;
  endtask
  // ****************************************
  // Verdict and watchdog
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // The tests take about 42000 cycles.
  initial begin
    repeat (90000) @(posedge aclk);
    miscompares++;
    print_verdict();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    axr(ACQ_CONFIG_OFF);
    `CHK(d, 32'h00000000)
    axr(ACQ_CONTROL_OFF);
    `CHK(d, 32'h0000003C)
    `CHK({cen, aen, cbias, abias}, 6'h0F)
    axr(ACQ_STATUS_OFF);
    `CHK(d, 32'h00000002)
    axr(8'h20);
    `CHK(resp, RESP_SLVERR)
    axw(8'h20, 32'h0000FFFF, 4'hF);
    `CHK(resp, RESP_SLVERR)
    $display("reset test done");
    // Table of conversions: length, saturation and forced low bits.
    axw(ACQ_CONTROL_OFF, 32'h000000FC, 4'h1);
    foreach (rows[k]) begin
      mbit <= rows[k].m;
      axw(ACQ_CONFIG_OFF, {25'h0, rows[k].n, rows[k].o, 2'h0}, 4'h1);
      axw(ACQ_CONTROL_OFF, 32'h000001FC, 4'h3);
      wait_done();
      `CHK(t, (1 << rows[k].n) * ((8 << rows[k].o) + 1) + 1)
      `CHK(chop, rows[k].n == 2'd0)
      chk_res(rows[k].r);
    end
    $display("table test done");
    // Alternate trigger; old result holds until the new one lands.
    mbit <= 0;
    axw(ACQ_CONFIG_OFF, 32'h00000014, 4'h1);
    axw(ACQ_CONTROL_OFF, 32'h000002FC, 4'h3);
    @(posedge aclk);
    `CHK(busy, 1'b1)
    `CHK(chop, 1'b0)
    axw(ACQ_CONTROL_OFF, 32'h000001FC, 4'h3);
    chk_res(16'h0001);
    wait_done();
    `CHK(t, 258)
    chk_res(16'h8000);
    $display("trigger test done");
    // Disabling mid-conversion aborts and keeps the result.
    axw(ACQ_CONTROL_OFF, 32'h000001FC, 4'h3);
    repeat (100) @(posedge aclk);
    axw(ACQ_CONTROL_OFF, 32'h0000003C, 4'h1);
    repeat (3) @(posedge aclk);
    `CHK(busy, 1'b0)
    `CHK({cen, aen}, 2'b00)
    t = 0;
    repeat (50) begin @(posedge aclk); t += tick; end
    `CHK(t, 0)
    chk_res(16'h8000);
    $display("abort test done");
    // Sampling period for each rate code.
    for (int c = 0; c < 4; c++) begin
      axw(ACQ_CONTROL_OFF, 32'h000000FC | c, 4'h1);
      do @(posedge aclk); while (tick !== 1'b1);
      t = 0;
      do begin @(posedge aclk); t++; end while (tick !== 1'b1 && t < 99);
      `CHK(t, per[c])
    end
    // Bias codes reach the pins and read back.
    for (int b = 0; b < 4; b++) begin
      axw(ACQ_CONTROL_OFF, 32'h000000C0 | (b << 2) | ((3 - b) << 4), 4'h1);
      `CHK(cbias, 2'(b))
      `CHK(abias, 2'(3 - b))
      axr(ACQ_CONTROL_OFF);
      `CHK(d[5:2], {2'(3 - b), 2'(b)})
    end
    $display("rate and bias test done");
    print_verdict();
  end
endmodule
